// ### src/tcs_pkg.sv
/*
 * Shared constants and state types of the thermometer configuration/status block.
 * Assumes a 125 MHz system clock; conversion times are derived from it.
 */
package tcs_pkg;

	// Byte addresses of the configuration register
	localparam logic [7:0] CFG_MSB_ADDR = 8'hAC;
	localparam logic [7:0] CFG_LSB_ADDR = 8'hAD;

	// Bit positions inside the upper byte
	localparam int BIT_DONE    = 7;
	localparam int BIT_NVB     = 6;
	localparam int BIT_HI      = 5;
	localparam int BIT_LO      = 4;
	localparam int BIT_RES_HI  = 3;
	localparam int BIT_RES_LO  = 2;
	localparam int BIT_POWER_UP_CONVERT   = 1;
	localparam int BIT_ONESHOT = 0;

	// Bit positions inside the lower byte
	localparam int BIT_PO_FUNC = 7;
	localparam int BIT_PO_POL  = 6;
	localparam int BIT_ADDR_HI = 5;
	localparam int BIT_ADDR_LO = 3;
	localparam int BIT_SCR_HI  = 2;
	localparam int BIT_SCR_LO  = 0;

	// Layout of the nonvolatile image presented at power-up
	localparam int NV_RES_HI  = 7;
	localparam int NV_RES_LO  = 6;
	localparam int NV_POWER_UP_CONVERT   = 5;
	localparam int NV_ONESHOT = 4;
	localparam int NV_PO_POL  = 3;
	localparam int NV_SCR_HI  = 2;
	localparam int NV_SCR_LO  = 0;

	// Resolution codes
	localparam logic [1:0] RES_10B = 2'h0;
	localparam logic [1:0] RES_11B = 2'h1;
	localparam logic [1:0] RES_12B = 2'h2;
	localparam logic [1:0] RES_13B = 2'h3;

	// Conversion timing
	localparam int unsigned CLK_KHZ      = 125000;
	localparam int unsigned CONV_MS_10B  = 25;
	localparam int unsigned CONV_MS_11B  = 50;
	localparam int unsigned CONV_MS_12B  = 100;
	localparam int unsigned CONV_MS_13B  = 200;
	localparam int unsigned CONV_CYC_10B = CONV_MS_10B * CLK_KHZ;
	localparam int unsigned CONV_CYC_11B = CONV_MS_11B * CLK_KHZ;
	localparam int unsigned CONV_CYC_12B = CONV_MS_12B * CLK_KHZ;
	localparam int unsigned CONV_CYC_13B = CONV_MS_13B * CLK_KHZ;

	typedef enum logic {ST_IDLE, ST_CONV} tcs_conv_st_t;

	typedef struct packed {
		logic         loaded;
		tcs_conv_st_t fsm;
		logic         cont;
		logic [1:0]   res;
		logic         power_up_convert;
		logic         oneshot;
		logic         po_func;
		logic         po_pol;
		logic [2:0]   scratch;
		logic         hi_flag;
		logic         lo_flag;
		logic         nonvolatile_busy_flag;
		logic         po_active;
		logic         po_oe;
		logic [2:0]   a_s1;
		logic [2:0]   a_s2;
		logic [2:0]   a_s3;
		logic [2:0]   a_flt;
		logic         a1_prev;
		logic [7:0]   rdata;
	} tcs_state_t;

	// Factory values until the nonvolatile image is taken one cycle after release
	localparam tcs_state_t TOP_RESET = '{
		loaded: 1'h0, fsm: ST_IDLE, cont: 1'h0, res: RES_13B, power_up_convert: 1'h0,
		oneshot: 1'h0, po_func: 1'h1, po_pol: 1'h0, scratch: 3'h0,
		hi_flag: 1'h0, lo_flag: 1'h0, nonvolatile_busy_flag: 1'h0, po_active: 1'h0, po_oe: 1'h0,
		a_s1: 3'h0, a_s2: 3'h0, a_s3: 3'h0, a_flt: 3'h0, a1_prev: 1'h0,
		rdata: 8'h00};

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [31:0] cnt;
		logic [31:0] len;
		logic [31:0] run;
	} tcs_tmr_state_t;

	localparam tcs_tmr_state_t TMR_RESET = '{
		busy: 1'h0, done: 1'h0, cnt: 32'h0, len: 32'h0, run: 32'h0};

endpackage

// ### src/tcs_conv_if.sv
/*
 * Link between the configuration logic and the conversion timer.
 * Assumes both ends share one clock; no timing lives here.
 */
`timescale 1ns/10ps
`default_nettype none
interface tcs_conv_if;
	logic       start;
	logic [1:0] res;
	logic       busy;
	logic       done;

	modport ctrl  (output start, output res, input busy, input done);
	modport timer (input start, input res, output busy, output done);
endinterface
`default_nettype wire

// ### src/tcs_conv_timer.sv
/*
 * Conversion timebase: runs for the time chosen by the resolution code,
 * then gives a one-cycle done pulse.
 * Assumes start is only raised while idle or in the cycle of done.
 */
`timescale 1ns/10ps
`default_nettype none
module tcs_conv_timer #(
	parameter int unsigned CYC_10B = tcs_pkg::CONV_CYC_10B,
	parameter int unsigned CYC_11B = tcs_pkg::CONV_CYC_11B,
	parameter int unsigned CYC_12B = tcs_pkg::CONV_CYC_12B,
	parameter int unsigned CYC_13B = tcs_pkg::CONV_CYC_13B
) (
	input  wire logic    clk_sys_i,
	input  wire logic    rst_n_i,
	tcs_conv_if.timer    tif
);
	tcs_pkg::tcs_tmr_state_t st;
	tcs_pkg::tcs_tmr_state_t next_st;
	logic [31:0]             sel;

	always_comb begin
		unique case (tif.res)
			tcs_pkg::RES_10B: sel = CYC_10B;
			tcs_pkg::RES_11B: sel = CYC_11B;
			tcs_pkg::RES_12B: sel = CYC_12B;
			tcs_pkg::RES_13B: sel = CYC_13B;
		endcase
		next_st = st;
		next_st.done = 1'h0;
		if (tif.start) begin
			next_st.busy = 1'h1;
			next_st.cnt = sel;
			next_st.len = sel;
			next_st.run = 32'h0;
		end else if (st.busy) begin
			next_st.run = st.run + 32'h1;
			if (st.cnt == 32'h1) begin
				next_st.busy = 1'h0;
				next_st.done = 1'h1;
			end else begin
				next_st.cnt = st.cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			st <= tcs_pkg::TMR_RESET;
		else
			st <= next_st;
	end

	assign tif.busy = st.busy;
	assign tif.done = st.done;

	AST_TMR_LEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		st.done |-> st.run == st.len)
		else $error("conversion length differs from selected time");
	AST_TMR_SEL13: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tif.start && tif.res == tcs_pkg::RES_13B |=> st.busy && st.len == CYC_13B)
		else $error("13-bit conversion loaded wrong time");
	AST_TMR_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		st.done |=> !st.done)
		else $error("done pulse longer than one cycle");
endmodule // tcs_conv_timer
`default_nettype wire

// ### src/tcs_top.sv
/*
 * Configuration and status register of a digital thermometer with its
 * conversion control, threshold flags and programmable open-drain output.
 * Assumes a byte register port decoded from the serial bus, command pulses
 * from the command decoder, and temperature and trip points from the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tcs_top #(
	parameter int unsigned CONV_CYC_10B = tcs_pkg::CONV_CYC_10B,
	parameter int unsigned CONV_CYC_11B = tcs_pkg::CONV_CYC_11B,
	parameter int unsigned CONV_CYC_12B = tcs_pkg::CONV_CYC_12B,
	parameter int unsigned CONV_CYC_13B = tcs_pkg::CONV_CYC_13B
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        cmd_start_i,
	input  wire logic        cmd_stop_i,
	input  wire logic [7:0]  nv_image_i,
	input  wire logic        nv_busy_i,
	input  wire logic [2:0]  addr_pin_i,
	input  wire logic [15:0] temp_i,
	input  wire logic [15:0] upper_trip_point_i,
	input  wire logic [15:0] lower_trip_point_i,
	output logic             programmable_output_pin_o,
	output logic             programmable_output_pin_oe_o
);
	tcs_pkg::tcs_state_t st;
	tcs_pkg::tcs_state_t next_st;
	tcs_conv_if          conv ();

	logic wr_msb;
	logic wr_lsb;
	logic trig_mode;
	logic a1_rise;
	logic pwr_start;
	logic start_req;
	logic hi_hit;
	logic lo_hit;
	logic hi_clr;
	logic lo_clr;

	tcs_conv_timer #(
		.CYC_10B (CONV_CYC_10B),
		.CYC_11B (CONV_CYC_11B),
		.CYC_12B (CONV_CYC_12B),
		.CYC_13B (CONV_CYC_13B)
	) u_timer (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.tif       (conv.timer)
	);

	assign wr_msb = reg_wr_i && (reg_addr_i == tcs_pkg::CFG_MSB_ADDR);
	assign wr_lsb = reg_wr_i && (reg_addr_i == tcs_pkg::CFG_LSB_ADDR);

	// Pin one becomes a trigger only in standalone single mode
	assign trig_mode = st.power_up_convert && st.oneshot;
	assign a1_rise   = st.a_flt[1] && !st.a1_prev;

	// The image is taken in the first cycle after release, so power-up start uses it directly
	assign pwr_start = !st.loaded && nv_image_i[tcs_pkg::NV_POWER_UP_CONVERT];
	assign start_req = st.loaded && (cmd_start_i || (trig_mode && a1_rise));

	assign hi_hit = $signed(temp_i) >= $signed(upper_trip_point_i);
	assign lo_hit = $signed(temp_i) <= $signed(lower_trip_point_i);
	assign hi_clr = wr_msb && !reg_wdata_i[tcs_pkg::BIT_HI];
	assign lo_clr = wr_msb && !reg_wdata_i[tcs_pkg::BIT_LO];

	// Restart on done keeps continuous conversions back to back; a stop in that cycle wins
	assign conv.start = ((st.fsm == tcs_pkg::ST_IDLE) && (pwr_start || start_req))
		|| (conv.done && st.cont && !cmd_stop_i);
	assign conv.res = st.loaded ? st.res
		: nv_image_i[tcs_pkg::NV_RES_HI:tcs_pkg::NV_RES_LO];

	always_comb begin
		next_st = st;

		// Three-stage pin synchroniser; a level counts once stages two and three agree
		next_st.a_s1 = addr_pin_i;
		next_st.a_s2 = st.a_s1;
		next_st.a_s3 = st.a_s2;
		if (st.a_s2 == st.a_s3)
			next_st.a_flt = st.a_s3;
		next_st.a1_prev = st.a_flt[1];

		next_st.nonvolatile_busy_flag = nv_busy_i;

		if (!st.loaded) begin
			next_st.loaded  = 1'h1;
			next_st.res     = nv_image_i[tcs_pkg::NV_RES_HI:tcs_pkg::NV_RES_LO];
			next_st.power_up_convert   = nv_image_i[tcs_pkg::NV_POWER_UP_CONVERT];
			next_st.oneshot = nv_image_i[tcs_pkg::NV_ONESHOT];
			next_st.po_pol  = nv_image_i[tcs_pkg::NV_PO_POL];
			next_st.scratch = nv_image_i[tcs_pkg::NV_SCR_HI:tcs_pkg::NV_SCR_LO];
			next_st.cont    = nv_image_i[tcs_pkg::NV_POWER_UP_CONVERT]
				&& !nv_image_i[tcs_pkg::NV_ONESHOT];
		end else begin
			// Done, busy and address bits have no write path
			if (wr_msb) begin
				next_st.res     = reg_wdata_i[tcs_pkg::BIT_RES_HI:tcs_pkg::BIT_RES_LO];
				next_st.power_up_convert   = reg_wdata_i[tcs_pkg::BIT_POWER_UP_CONVERT];
				next_st.oneshot = reg_wdata_i[tcs_pkg::BIT_ONESHOT];
			end
			if (wr_lsb) begin
				next_st.po_func = reg_wdata_i[tcs_pkg::BIT_PO_FUNC];
				next_st.po_pol  = reg_wdata_i[tcs_pkg::BIT_PO_POL];
				next_st.scratch = reg_wdata_i[tcs_pkg::BIT_SCR_HI:tcs_pkg::BIT_SCR_LO];
			end
		end

		unique case (st.fsm)
			tcs_pkg::ST_IDLE: begin
				if (conv.start) begin
					next_st.fsm = tcs_pkg::ST_CONV;
					if (start_req)
						next_st.cont = !st.oneshot;
				end
			end
			tcs_pkg::ST_CONV: begin
				// Mode bit is not looked at here; a cleared run flag or a stop in the done cycle ends repetition
				if (conv.done && !conv.start)
					next_st.fsm = tcs_pkg::ST_IDLE;
			end
		endcase

		// Stop lets the running conversion finish but prevents the restart
		if (cmd_stop_i)
			next_st.cont = 1'h0;

		// Set wins over a software clear in the same cycle
		next_st.hi_flag = (st.hi_flag && !hi_clr) || (conv.done && hi_hit);
		next_st.lo_flag = (st.lo_flag && !lo_clr) || (conv.done && lo_hit);

		if (conv.done) begin
			if (st.po_pol) begin
				if (hi_hit)
					next_st.po_active = 1'h1;
				else if (lo_hit)
					next_st.po_active = 1'h0;
			end else begin
				if (lo_hit)
					next_st.po_active = 1'h1;
				else if (hi_hit)
					next_st.po_active = 1'h0;
			end
		end
		// Pin is active low: enabling the driver pulls it down
		next_st.po_oe = !next_st.po_func || next_st.po_active;

		unique case (reg_addr_i)
			tcs_pkg::CFG_MSB_ADDR: next_st.rdata = {st.fsm == tcs_pkg::ST_IDLE, st.nonvolatile_busy_flag,
				st.hi_flag, st.lo_flag, st.res, st.power_up_convert, st.oneshot};
			tcs_pkg::CFG_LSB_ADDR: next_st.rdata = {st.po_func, st.po_pol,
				st.a_flt, st.scratch};
			default: next_st.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			st <= tcs_pkg::TOP_RESET;
		else
			st <= next_st;
	end

	assign reg_rdata_o                  = st.rdata;
	assign programmable_output_pin_o    = 1'h0;
	assign programmable_output_pin_oe_o = st.po_oe;

	sequence seq_idle_start;
		st.loaded && st.fsm == tcs_pkg::ST_IDLE && cmd_start_i;
	endsequence

	sequence seq_end_repeat;
		conv.done && st.cont && !cmd_stop_i;
	endsequence

	sequence seq_end_single;
		conv.done && !st.cont;
	endsequence

	AST_DONE_READ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_addr_i == tcs_pkg::CFG_MSB_ADDR ##1 1'h1
		|-> reg_rdata_o[tcs_pkg::BIT_DONE] == ($past(st.fsm) == tcs_pkg::ST_IDLE))
		else $error("done bit does not track conversion state");
	AST_PWR_AUTO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		pwr_start |=> st.fsm == tcs_pkg::ST_CONV ##1 conv.busy)
		else $error("power-up conversion did not start");
	AST_PWR_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!st.loaded && !nv_image_i[tcs_pkg::NV_POWER_UP_CONVERT] |=> st.fsm == tcs_pkg::ST_IDLE)
		else $error("device left idle at power-up without autostart");
	AST_NVB: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		##1 st.nonvolatile_busy_flag == $past(nv_busy_i))
		else $error("busy bit does not follow cell write");
	AST_HI_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		conv.done && hi_hit |=> st.hi_flag)
		else $error("high flag missed");
	AST_LO_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		conv.done && lo_hit |=> st.lo_flag)
		else $error("low flag missed");
	AST_FLAG_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		st.hi_flag && !hi_clr |=> st.hi_flag)
		else $error("high flag dropped without clear");
	AST_SINGLE_END: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		seq_end_single |=> st.fsm == tcs_pkg::ST_IDLE && !conv.busy)
		else $error("single conversion did not return to standby");
	AST_CMD_START: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		seq_idle_start ##0 !st.oneshot && !cmd_stop_i |=> st.cont ##1 conv.busy)
		else $error("start command did not launch continuous mode");
	AST_REPEAT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		seq_end_repeat |=> st.fsm == tcs_pkg::ST_CONV && conv.busy)
		else $error("continuous conversions halted");
	AST_TRIGGER: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		st.loaded && st.fsm == tcs_pkg::ST_IDLE && trig_mode && a1_rise
		|=> st.fsm == tcs_pkg::ST_CONV)
		else $error("pin trigger ignored");
	AST_FORCE_LOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		st.loaded && wr_lsb && !reg_wdata_i[tcs_pkg::BIT_PO_FUNC] |=> programmable_output_pin_oe_o)
		else $error("output not forced low");
	AST_ADDR_FLT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		st.a_s2 == st.a_s3 |=> st.a_flt == $past(st.a_s3))
		else $error("address readback not updated");
endmodule // tcs_top
`default_nettype wire

// ### verif/tcs_master_model.sv
/*
 * Bus master model: issues byte register accesses and start/stop commands.
 * Assumes the block samples on the rising edge; everything here moves on falling edges.
 */
`timescale 1ns/10ps
`default_nettype none
module tcs_master_model (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] reg_rdata_i,
	output var  logic [7:0] reg_addr_o,
	output var  logic       reg_wr_o,
	output var  logic [7:0] reg_wdata_o,
	output var  logic       cmd_start_o,
	output var  logic       cmd_stop_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		cmd_start_o = 1'b0;
		cmd_stop_o = 1'b0;
	end

	// Data is inverted after the strobe so a stale byte is never taken for a new one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_wr_o = 1'b1;
		reg_wdata_o = d;
		@(negedge clk_sys_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		@(negedge clk_sys_i);
		d = reg_rdata_i;
	endtask

	// Stop is sent before single mode is used again after continuous running
	task automatic cmd(input logic stop);
		@(negedge clk_sys_i);
		cmd_start_o = !stop;
		cmd_stop_o = stop;
		@(negedge clk_sys_i);
		cmd_start_o = 1'b0;
		cmd_stop_o = 1'b0;
	endtask
endmodule // tcs_master_model
`default_nettype wire

// ### verif/thermometer_config_status_tb_top.sv
/*
 * Self-checking bench for the configuration/status block.
 * Assumes shortened conversion counts of 20/40/60/80 cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module thermometer_config_status_tb_top;
	localparam int CONV [4] = '{20, 40, 60, 80};
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  nv_image_i;
	logic        nv_busy_i;
	logic [2:0]  addr_pin_i;
	logic [15:0] temp_i;
	logic [15:0] upper_i;
	logic [15:0] lower_i;
	wire  [7:0]  rdata, addr, wdata;
	wire         wr, start, stop, po, oe;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n;
	logic [7:0]  v;

	always #4 clk_sys_i = ~clk_sys_i;

	tcs_top #(.CONV_CYC_10B(20), .CONV_CYC_11B(40), .CONV_CYC_12B(60), .CONV_CYC_13B(80))
	tcs_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .cmd_start_i(start), .cmd_stop_i(stop),
		.nv_image_i(nv_image_i), .nv_busy_i(nv_busy_i), .addr_pin_i(addr_pin_i),
		.temp_i(temp_i), .upper_trip_point_i(upper_i), .lower_trip_point_i(lower_i),
		.programmable_output_pin_o(po), .programmable_output_pin_oe_o(oe));

	tcs_master_model tcs_master_model_i (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata),
		.reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .cmd_start_o(start),
		.cmd_stop_o(stop));

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Whole run needs under 1500 cycles
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		tcs_master_model_i.rd(a, v);
		check(what, {8'h00, v}, {8'h00, exp});
	endtask

	// Polls the done bit; a block that never clears it returns a short length
	task automatic conv_len(output int len);
		int t;
		t = cyc;
		do tcs_master_model_i.rd(8'hAC, v); while (v[7] !== 1'b1 && cyc - t < 400);
		len = cyc - t;
	endtask

	task automatic do_reset(input logic [7:0] img);
		@(negedge clk_sys_i);
		rst_n_i = 1'b0;
		nv_image_i = img;
		repeat (10) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
	endtask

	initial begin
		nv_image_i = 8'h9D;
		nv_busy_i = 1'b0;
		addr_pin_i = 3'h5;
		temp_i = 16'h0200;
		upper_i = 16'h0100;
		lower_i = 16'h0080;
		do_reset(8'h9D);
		rchk(8'hAC, 8'h89, "upper after reset");
		rchk(8'hAD, 8'hED, "lower after reset");
		rchk(8'hAE, 8'h00, "unmapped byte");
		check("pin idle", {14'h0, po, oe}, 16'h0000);
		tcs_master_model_i.wr(8'hAD, 8'h02);
		rchk(8'hAD, 8'h2A, "lower write");
		check("forced low", {15'h0, oe}, 16'h0001);
		tcs_master_model_i.wr(8'hAD, 8'hC5);
		nv_busy_i = 1'b1;
		tcs_master_model_i.wr(8'hAC, 8'h49);
		rchk(8'hAC, 8'hC9, "busy, read-only");
		nv_busy_i = 1'b0;
		for (int r = 0; r < 4; r++) begin
			tcs_master_model_i.wr(8'hAC, {4'h0, r[1:0], 2'h1});
			tcs_master_model_i.cmd(1'b0);
			conv_len(n);
			check("conv length", {15'h0, n >= CONV[r] && n <= CONV[r] + 8}, 16'h0001);
		end
		check("over-temp active", {15'h0, oe}, 16'h0001);
		repeat (100) @(negedge clk_sys_i);
		rchk(8'hAC, 8'hAD, "high flag, idle");
		tcs_master_model_i.wr(8'hAC, 8'h3D);
		rchk(8'hAC, 8'hAD, "flag write 1");
		tcs_master_model_i.wr(8'hAC, 8'h0D);
		rchk(8'hAC, 8'h8D, "flag cleared");
		temp_i = 16'h0080;
		tcs_master_model_i.cmd(1'b0);
		conv_len(n);
		rchk(8'hAC, 8'h9D, "low flag");
		check("over-temp released", {15'h0, oe}, 16'h0000);
		tcs_master_model_i.wr(8'hAD, 8'h85);
		tcs_master_model_i.cmd(1'b0);
		conv_len(n);
		check("under-temp active", {15'h0, oe}, 16'h0001);
		// Trip points moved below the reading: under-temp output must let go
		upper_i = 16'h0060;
		lower_i = 16'h0040;
		tcs_master_model_i.cmd(1'b0);
		conv_len(n);
		check("under-temp released", {15'h0, oe}, 16'h0000);
		rchk(8'hAC, 8'hBD, "high flag, moved trip point");
		upper_i = 16'h0100;
		lower_i = 16'h0080;
		// Continuous running shows as the high flag coming back after a clear
		temp_i = 16'h0200;
		tcs_master_model_i.wr(8'hAC, 8'h00);
		tcs_master_model_i.cmd(1'b0);
		repeat (60) @(negedge clk_sys_i);
		tcs_master_model_i.wr(8'hAC, 8'h00);
		repeat (50) @(negedge clk_sys_i);
		tcs_master_model_i.rd(8'hAC, v);
		check("repeats", {15'h0, v[5]}, 16'h0001);
		tcs_master_model_i.wr(8'hAC, 8'h01);
		repeat (50) @(negedge clk_sys_i);
		tcs_master_model_i.rd(8'hAC, v);
		check("single set, still running", {15'h0, v[5]}, 16'h0001);
		tcs_master_model_i.cmd(1'b1);
		repeat (50) @(negedge clk_sys_i);
		tcs_master_model_i.wr(8'hAC, 8'h01);
		repeat (50) @(negedge clk_sys_i);
		rchk(8'hAC, 8'h81, "stopped");
		tcs_master_model_i.cmd(1'b0);
		conv_len(n);
		check("single after stop", {15'h0, n >= CONV[0] && n <= CONV[0] + 8}, 16'h0001);
		do_reset(8'h3D);
		tcs_master_model_i.rd(8'hAC, v);
		check("autostart single", {15'h0, v[7]}, 16'h0000);
		repeat (100) @(negedge clk_sys_i);
		rchk(8'hAC, 8'hA3, "one conversion then idle");
		addr_pin_i = 3'h7;
		repeat (8) @(negedge clk_sys_i);
		tcs_master_model_i.rd(8'hAC, v);
		check("pin trigger", {15'h0, v[7]}, 16'h0000);
		repeat (50) @(negedge clk_sys_i);
		rchk(8'hAD, 8'hFD, "address readback");
		do_reset(8'h2D);
		repeat (60) @(negedge clk_sys_i);
		tcs_master_model_i.wr(8'hAC, 8'h02);
		repeat (50) @(negedge clk_sys_i);
		tcs_master_model_i.rd(8'hAC, v);
		check("autostart continuous", {15'h0, v[5]}, 16'h0001);
		tally_and_finish();
	end
endmodule // thermometer_config_status_tb_top
`default_nettype wire
